// >>> ptm_pkg.sv
// Shared constants and types for the three-channel period timer
package ptm_pkg;

	// Number of timer channels
	localparam int TIMER_COUNT = 3;

	// Register byte offsets inside one channel window
	localparam logic [3:0] OFS_COUNT   = 4'h0;
	localparam logic [3:0] OFS_PERIOD  = 4'h4;
	localparam logic [3:0] OFS_CONTROL = 4'h8;
	localparam logic [3:0] OFS_LIMIT   = 4'hC;
	// Channel window stride and the shared status word
	localparam logic [7:0] CHAN_STRIDE = 8'h10;
	localparam logic [7:0] OFS_STATUS  = 8'h30;

	// Control field positions
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_PRE_LSB  = 1;
	localparam int CTRL_POST_LSB = 4;
	// Limit register mode field position
	localparam int MODE_LSB = 0;

	// Reset values
	localparam logic [7:0] RST_COUNT   = 8'h00;
	localparam logic [7:0] RST_PERIOD  = 8'hFF;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [4:0] RST_MODE    = 5'h00;

	// Mode families in mode bits 4:3
	localparam logic [1:0] FAM_FREE = 2'h0;
	localparam logic [1:0] FAM_ONE  = 2'h1;
	localparam logic [1:0] FAM_MONO = 2'h2;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register layout
	typedef struct packed {
		logic [3:0] postscale_select;
		logic [2:0] prescale_select;
		logic       timer_enable_bit;
	} ptm_ctrl_type;

	// Decoded register address
	typedef struct packed {
		logic       hit;
		logic       status;
		logic [1:0] chan;
		logic [1:0] sel;
	} ptm_addr_type;

endpackage

// >>> ptm_sync3.sv
// Three-stage input synchroniser with agreement filter
module ptm_sync3
	import ptm_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] async_in,
	output      logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	// Shift chain; output moves once stages two and three agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_r     <= '0;
			s2_r     <= '0;
			s3_r     <= '0;
			sync_out <= '0;
		end
		else
		begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < WIDTH; i++)
				if (s2_r[i] == s3_r[i])
					sync_out[i] <= s3_r[i];
		end
	end
endmodule

// >>> ptm_prescaler.sv
// Power-of-two prescaler giving one-cycle timer clock enables
module ptm_prescaler
	import ptm_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       clear,
	input  wire logic       run,
	input  wire logic [2:0] sel,
	output      logic       tick
);
	logic [6:0] cnt_r;
	logic [6:0] limit;

	// Ratio is two to the power of sel, 1:1 up to 1:128
	assign limit = 7'((8'h01 << sel) - 8'h01);
	assign tick  = run && !clear && (cnt_r == limit);

	// Divider count, cleared on request or at full
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_r <= '0;
		else if (clear || tick)
			cnt_r <= '0;
		else if (run)
			cnt_r <= cnt_r + 7'h01;
	end
endmodule

// >>> ptm_timer.sv
// Three-channel 8-bit period timer with an AXI4-Lite register slave
//
// Overview of operation
// - 8-bit count and period per channel
// - Prescaler divides 1:1 up to 1:128
// - Postscaler divides 1:1 up to 1:16
// - Count advances on each prescaler tick
// - Match signals postscaler, count returns zero
// - Postscale match emits pulse, clears count
// - Gate modes hold count while gate inactive
// - Reset modes clear count on level/edge
// - Count readable, writable, zero after reset
// - Period double-buffered, both reset to FF
// - Active period loads only on listed events
// - Listed events clear prescaler and postscaler
// - Control write leaves count unchanged
// - One-shot clears enable, stops at match
// - One-shot restart resets the postscaler
// - Monostable stops at match, edge restarts
// - Three identical independent timer channels
// - Debug freeze ignores external triggers
module ptm_timer
	import ptm_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output      logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output      logic        s_axi_wready,
	output      logic [1:0]  s_axi_bresp,
	output      logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output      logic        s_axi_arready,
	output      logic [31:0] s_axi_rdata,
	output      logic [1:0]  s_axi_rresp,
	output      logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [2:0]  ext_reset_signal,
	input  wire logic        debug_freeze,
	output      logic [2:0]  postscaled_pulse
);
	// Address decode shared by the read and write paths
	function automatic ptm_addr_type decode(input logic [7:0] a);
		ptm_addr_type d;
		d.chan   = 2'(a / CHAN_STRIDE);
		d.sel    = a[3:2];
		d.status = (a == OFS_STATUS);
		d.hit    = (a[1:0] == 2'h0) &&
			((d.chan != 2'h3) || d.status);
		return d;
	endfunction

	// Edge selection: 1 rising, 2 falling, 3 either
	function automatic logic edge_hit(input logic [1:0] s,
		input logic rise, input logic fall);
		return (s[0] && rise) || (s[1] && fall);
	endfunction

	logic [7:0]   aw_addr_r;
	logic         aw_got_r;
	logic [7:0]   w_data_r;
	logic         w_lane_r;
	logic         w_got_r;
	logic         wr_do;
	ptm_addr_type wr_dec;
	ptm_addr_type rd_dec;
	logic [2:0]   wr_count;
	logic [2:0]   wr_period;
	logic [2:0]   wr_ctrl;
	logic [2:0]   wr_limit;
	logic         wr_status;
	logic [2:0]   ers;

	logic [7:0]   count_r   [3];
	logic [7:0]   per_sw_r  [3];
	logic [7:0]   per_act_r [3];
	ptm_ctrl_type ctrl_r    [3];
	logic [4:0]   mode_r    [3];
	logic [2:0]   flag_r;

	// Write address channel capture
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			aw_got_r      <= 1'b0;
			aw_addr_r     <= '0;
		end
		else if (s_axi_awready && s_axi_awvalid)
		begin
			s_axi_awready <= 1'b0;
			aw_got_r      <= 1'b1;
			aw_addr_r     <= s_axi_awaddr;
		end
		else
		begin
			if (wr_do)
				aw_got_r <= 1'b0;
			s_axi_awready <= s_axi_awvalid && !aw_got_r &&
				!s_axi_bvalid && !s_axi_awready;
		end
	end

	// Write data channel capture, low byte lane only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b0;
			w_got_r      <= 1'b0;
			w_data_r     <= '0;
			w_lane_r     <= 1'b0;
		end
		else if (s_axi_wready && s_axi_wvalid)
		begin
			s_axi_wready <= 1'b0;
			w_got_r      <= 1'b1;
			w_data_r     <= s_axi_wdata[7:0];
			w_lane_r     <= s_axi_wstrb[0];
		end
		else
		begin
			if (wr_do)
				w_got_r <= 1'b0;
			s_axi_wready <= s_axi_wvalid && !w_got_r &&
				!s_axi_bvalid && !s_axi_wready;
		end
	end

	// Commit once address and data are both held
	assign wr_do     = aw_got_r && w_got_r && !s_axi_bvalid;
	assign wr_dec    = decode(aw_addr_r);
	assign wr_status = wr_do && w_lane_r && wr_dec.hit && wr_dec.status;

	// Per-channel one-cycle write strobes
	always_comb
	begin
		for (int i = 0; i < TIMER_COUNT; i++)
		begin
			logic sel_ch;
			sel_ch = wr_do && w_lane_r && wr_dec.hit &&
				!wr_dec.status && (wr_dec.chan == 2'(i));
			wr_count[i]  = sel_ch && (wr_dec.sel == OFS_COUNT[3:2]);
			wr_period[i] = sel_ch && (wr_dec.sel == OFS_PERIOD[3:2]);
			wr_ctrl[i]   = sel_ch && (wr_dec.sel == OFS_CONTROL[3:2]);
			wr_limit[i]  = sel_ch && (wr_dec.sel == OFS_LIMIT[3:2]);
		end
	end

	// Write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (wr_do)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_dec.hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Read channel: one read at a time, data registered
	assign rd_dec = decode(s_axi_araddr);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (s_axi_arready && s_axi_arvalid)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= rd_dec.hit ? RESP_OKAY : RESP_SLVERR;
			s_axi_rdata   <= '0;
			if (rd_dec.hit && rd_dec.status)
				s_axi_rdata[2:0] <= flag_r;
			else if (rd_dec.hit)
				unique case (rd_dec.sel)
					OFS_COUNT[3:2]:
						s_axi_rdata[7:0] <= count_r[rd_dec.chan];
					OFS_PERIOD[3:2]:
						s_axi_rdata[7:0] <= per_sw_r[rd_dec.chan];
					OFS_CONTROL[3:2]:
						s_axi_rdata[7:0] <= ctrl_r[rd_dec.chan];
					OFS_LIMIT[3:2]:
						s_axi_rdata[4:0] <= mode_r[rd_dec.chan];
				endcase
		end
		else
		begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			s_axi_arready <= s_axi_arvalid && !s_axi_rvalid &&
				!s_axi_arready;
		end
	end

	// External reset inputs come from outside the clock domain
	ptm_sync3 #(
		.WIDTH    (3)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (ext_reset_signal),
		.sync_out (ers)
	);

	for (genvar g = 0; g < TIMER_COUNT; g++)
	begin : g_chan
		logic       ers_prev_r;
		logic       en_prev_r;
		logic       run_r;
		logic [3:0] post_cnt_r;
		logic       rise;
		logic       fall;
		logic       gate;
		logic       rst_ev;
		logic       start_ev;
		logic       running;
		logic       tick;
		logic       match;
		logic       post_hit;
		logic       scl_clear;
		logic [1:0] fam;
		logic [2:0] sub;

		assign fam  = mode_r[g][4:3];
		assign sub  = mode_r[g][2:0];
		assign rise = ers[g] && !ers_prev_r && !debug_freeze;
		assign fall = !ers[g] && ers_prev_r && !debug_freeze;

		always_comb
		begin
			gate = 1'b1;
			if (fam == FAM_FREE)
				unique case (sub)
					3'h1, 3'h6: gate = ers[g];
					3'h2, 3'h7: gate = !ers[g];
					default:    gate = 1'b1;
				endcase
		end

		always_comb
		begin
			rst_ev = 1'b0;
			if (fam == FAM_FREE)
				unique case (sub)
					3'h3:    rst_ev = rise || fall;
					3'h4:    rst_ev = rise;
					3'h5:    rst_ev = fall;
					3'h6:    rst_ev = !ers[g] && !debug_freeze;
					3'h7:    rst_ev = ers[g] && !debug_freeze;
					default: rst_ev = 1'b0;
				endcase
			else if (fam == FAM_ONE)
				unique case (sub)
					3'h4:    rst_ev = rise;
					3'h5:    rst_ev = fall;
					3'h6:    rst_ev = !ers[g] && !debug_freeze;
					3'h7:    rst_ev = ers[g] && !debug_freeze;
					default: rst_ev = 1'b0;
				endcase
		end

		// Start conditions for one-shot and monostable
		assign start_ev = ctrl_r[g].timer_enable_bit && (
			(fam == FAM_ONE && sub == 3'h0 && !en_prev_r) ||
			(fam != FAM_FREE && sub[2] == 1'b0 &&
				edge_hit(sub[1:0], rise, fall)) ||
			(fam == FAM_ONE && sub[2] &&
				edge_hit({sub[0], !sub[0]}, rise, fall)));

		assign running = ctrl_r[g].timer_enable_bit &&
			((fam == FAM_FREE) ? gate : run_r);
		assign scl_clear = wr_count[g] || wr_ctrl[g] || rst_ev;

		ptm_prescaler u_pre (
			.aclk    (aclk),
			.aresetn (aresetn),
			.clear   (scl_clear),
			.run     (running),
			.sel     (ctrl_r[g].prescale_select),
			.tick    (tick)
		);

		assign match    = tick && (count_r[g] == per_act_r[g]);
		// postscale ratio select value plus one
		assign post_hit = match &&
			(post_cnt_r == ctrl_r[g].postscale_select);

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				count_r[g] <= RST_COUNT;
			else if (wr_count[g])
				count_r[g] <= w_data_r;
			else if (rst_ev || match)
				count_r[g] <= RST_COUNT;
			else if (tick)
				count_r[g] <= count_r[g] + 8'h01;
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				per_sw_r[g] <= RST_PERIOD;
			else if (wr_period[g])
				per_sw_r[g] <= w_data_r;
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				per_act_r[g] <= RST_PERIOD;
			else if (wr_count[g] || wr_ctrl[g] || wr_limit[g] ||
				match || rst_ev)
				per_act_r[g] <= per_sw_r[g];
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				ctrl_r[g] <= RST_CONTROL;
			else if (wr_ctrl[g])
				ctrl_r[g] <= w_data_r;
			else if (match && fam == FAM_ONE)
				ctrl_r[g].timer_enable_bit <= 1'b0;
		end

		// Mode select register
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				mode_r[g] <= RST_MODE;
			else if (wr_limit[g])
				mode_r[g] <= w_data_r[MODE_LSB +: 5];
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				run_r <= 1'b0;
			else if (!ctrl_r[g].timer_enable_bit)
				run_r <= 1'b0;
			else if (start_ev)
				run_r <= 1'b1;
			else if (match && fam != FAM_FREE)
				run_r <= 1'b0;
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				post_cnt_r <= '0;
			else if (scl_clear || (start_ev && fam == FAM_ONE))
				post_cnt_r <= '0;
			else if (post_hit)
				post_cnt_r <= '0;
			else if (match)
				post_cnt_r <= post_cnt_r + 4'h1;
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				postscaled_pulse[g] <= 1'b0;
			else
				postscaled_pulse[g] <= post_hit;
		end

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				flag_r[g] <= 1'b0;
			else if (post_hit)
				flag_r[g] <= 1'b1;
			else if (wr_status && w_data_r[g])
				flag_r[g] <= 1'b0;
		end

		// Edge history for triggers and software start
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				ers_prev_r <= 1'b0;
				en_prev_r  <= 1'b0;
			end
			else
			begin
				ers_prev_r <= ers[g];
				en_prev_r  <= ctrl_r[g].timer_enable_bit;
			end
		end
	end
endmodule

// >>> ptm_timer_assertions.sv
// Bus handshake and read data checks on the timer slave
module ptm_timer_chk
	import ptm_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Address ready is a single-cycle pulse
	property p_aw_pulse;
		s_axi_awready |=> !s_axi_awready;
	endproperty
	a_aw_pulse: assert property (p_aw_pulse)
		else $error("awready longer than one cycle");

	// Data ready is a single-cycle pulse
	property p_w_pulse;
		s_axi_wready |=> !s_axi_wready;
	endproperty
	a_w_pulse: assert property (p_w_pulse)
		else $error("wready longer than one cycle");

	// Response follows data acceptance by two cycles
	property p_b_cause;
		$rose(s_axi_bvalid) |-> $past(s_axi_wready, 2);
	endproperty
	a_b_cause: assert property (p_b_cause)
		else $error("write response without accepted data");

	// No new write taken while a response waits
	property p_b_refuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_refuse: assert property (p_b_refuse)
		else $error("write accepted during response");

	// Read data one cycle after address taken
	property p_r_latency;
		s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_latency: assert property (p_r_latency)
		else $error("read data late");

	// No read address taken while data waits
	property p_r_refuse;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_r_refuse: assert property (p_r_refuse)
		else $error("read accepted during data");

	// Registers are eight bits wide
	property p_r_width;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_r_width: assert property (p_r_width)
		else $error("read data above bit 7");

	// Error reads return zero and a known code
	property p_r_err;
		s_axi_rvalid && s_axi_rresp != RESP_OKAY
			|-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000;
	endproperty
	a_r_err: assert property (p_r_err)
		else $error("bad error read");
endmodule

bind ptm_timer ptm_timer_chk i_ptm_timer_chk (.aclk, .aresetn,
	.s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rdata, .s_axi_rresp);

// >>> ptm_ers_model.sv
// External reset source driving all three channel inputs
module ptm_ers_model
(
	input  wire logic       aclk,
	input  wire logic [2:0] want,
	output      logic [2:0] ers
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] hold_r;

	// Start low with no pending hold
	initial
	begin
		ers = 3'h0;
		hold_r = 3'h0;
	end

	always @(posedge aclk)
	begin
		if (hold_r != 3'h0)
			hold_r <= hold_r - 3'h1;
		else if (want != ers)
		begin
			ers <= want;
			hold_r <= 3'h6;
		end
	end
endmodule

// >>> ptm_timer_test.sv
// Register level tests of the three-channel period timer
module ptm_timer_test
	import ptm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] PRE_T [3] = '{3'h0, 3'h1, 3'h7};
	localparam logic [3:0] POST_T [3] = '{4'h0, 4'h2, 4'hF};
	logic        aclk, aresetn, debug_freeze;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, c1;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [2:0]  ext_reset_signal, ers_want, postscaled_pulse;
	int          mismatches, comparisons, g, k, e;

	ptm_timer i_ptm_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .ext_reset_signal,
		.debug_freeze, .postscaled_pulse);
	ptm_ers_model i_ptm_ers_model (.aclk, .want(ers_want),
		.ers(ext_reset_signal));

	// Clock at 25 ns
	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	// One write, held until each channel is taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wvalid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		rs = s_axi_bresp;
		chk(32'(n < 50), 32'h1, "write timeout");
	endtask

	// One read, held until the address is taken
	task automatic rdr(input logic [7:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		chk(32'(n < 50), 32'h1, "read timeout");
	endtask

	// Byte address of a channel register
	function automatic logic [7:0] ra(input int ch, input logic [3:0] o);
		return 8'(ch) * CHAN_STRIDE + {4'h0, o};
	endfunction

	// Control byte from its fields
	function automatic logic [7:0] cv(input logic [3:0] po,
		input logic [2:0] pr, input logic en);
		ptm_ctrl_type c;
		c = '{po, pr, en};
		return c;
	endfunction

	// Cycles between two pulses of a channel
	task automatic gap(input int ch, output int n);
		n = 0;
		while (postscaled_pulse[ch] !== 1'b1 && n < 20000)
		begin
			@(posedge aclk);
			n++;
		end
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end while (postscaled_pulse[ch] !== 1'b1 && n < 20000);
	endtask

	// Pulses of a channel over a window
	task automatic cnt(input int ch, input int cyc, output int n);
		n = 0;
		repeat (cyc)
		begin
			@(posedge aclk);
			n += int'(postscaled_pulse[ch] === 1'b1);
		end
	endtask

	// Verdict and end of run
	task automatic results;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hang guard
	initial
	begin
		repeat (40000) @(posedge aclk);
		mismatches++;
		results;
	end

	// Main sequence
	initial
	begin
		aresetn = 1'b0;
		debug_freeze = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		ers_want = 3'h0;
		mismatches = 0;
		comparisons = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (k = 0; k < TIMER_COUNT; k++)
		begin
			rdr(ra(k, OFS_COUNT));
			chk(rd, 32'h0, "count reset");
			rdr(ra(k, OFS_PERIOD));
			chk(rd, 32'hFF, "period reset");
		end
		wr(ra(0, OFS_COUNT), 8'h05);
		wr(ra(0, OFS_CONTROL), 8'h00);
		rdr(ra(0, OFS_COUNT));
		chk(rd, 32'h5, "count after control write");
		wr(ra(1, OFS_PERIOD), 8'h03);
		for (k = 0; k < 3; k++)
		begin
			wr(ra(1, OFS_CONTROL), cv(POST_T[k], PRE_T[k], 1'b1));
			gap(1, g);
			e = (4 << PRE_T[k]) * (POST_T[k] + 1);
			chk(32'(g), 32'(e), "spacing");
		end
		rdr(OFS_STATUS);
		chk(rd & 32'h2, 32'h2, "flag set");
		wr(ra(1, OFS_CONTROL), 8'h00);
		wr(OFS_STATUS, 8'h02);
		rdr(OFS_STATUS);
		chk(rd, 32'h0, "flag cleared");
		wr(ra(2, OFS_LIMIT), 8'h08);
		wr(ra(2, OFS_PERIOD), 8'h06);
		for (k = 0; k < 2; k++)
		begin
			wr(ra(2, OFS_CONTROL), 8'h01);
			cnt(2, 40, g);
			chk(32'(g), 32'h1, "one-shot pulses");
			rdr(ra(2, OFS_CONTROL));
			chk(rd, 32'h0, "enable cleared");
		end
		wr(ra(0, OFS_LIMIT), 8'h01);
		wr(ra(0, OFS_CONTROL), 8'h01);
		repeat (20) @(posedge aclk);
		rdr(ra(0, OFS_COUNT));
		chk(rd, 32'h5, "gate holds");
		ers_want <= 3'h1;
		repeat (20) @(posedge aclk);
		rdr(ra(0, OFS_COUNT));
		chk(32'(rd > 32'hD), 32'h1, "gate runs");
		wr(ra(0, OFS_LIMIT), 8'h04);
		ers_want <= 3'h0;
		repeat (40) @(posedge aclk);
		rdr(ra(0, OFS_COUNT));
		chk(32'(rd > 32'd30), 32'h1, "runs before edge");
		ers_want <= 3'h1;
		repeat (12) @(posedge aclk);
		rdr(ra(0, OFS_COUNT));
		chk(32'(rd < 32'd20), 32'h1, "edge reset");
		c1 = rd;
		debug_freeze <= 1'b1;
		ers_want <= 3'h0;
		repeat (20) @(posedge aclk);
		ers_want <= 3'h1;
		repeat (20) @(posedge aclk);
		rdr(ra(0, OFS_COUNT));
		chk(32'(rd > c1 + 32'd40), 32'h1, "frozen trigger");
		debug_freeze <= 1'b0;
		rdr(8'h34);
		chk(32'(rs), 32'(RESP_SLVERR), "unmapped read");
		chk(rd, 32'h0, "unmapped data");
		wr(8'h35, 8'h01);
		chk(32'(rs), 32'(RESP_SLVERR), "misaligned write");
		// Count write reloads the active period of channel 0
		wr(ra(0, OFS_PERIOD), 8'h02);
		wr(ra(0, OFS_COUNT), 8'h00);
		gap(0, g);
		chk(32'(g), 32'h3, "count write reload");
		// Monostable on channel 2, rising edge start, twice
		wr(ra(2, OFS_LIMIT), 8'h11);
		wr(ra(2, OFS_CONTROL), 8'h01);
		for (k = 0; k < 2; k++)
		begin
			ers_want <= 3'h5;
			cnt(2, 40, g);
			chk(32'(g), 32'h1, "monostable pulses");
			ers_want <= 3'h1;
			repeat (10) @(posedge aclk);
		end
		rdr(ra(2, OFS_CONTROL));
		chk(rd, 32'h1, "monostable enable kept");
		results;
	end
endmodule
